// ---- rtl/rwc_pkg.sv ----
// Package: constants and types for the reset and watchdog block
package rwc_pkg;
  localparam logic [3:0] ADDR_WDT_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_RST_CAUSE  = 4'h4;
  localparam logic [3:0] ADDR_WDT_CMD    = 4'h8;
  localparam logic [3:0] ADDR_ANA_CTRL   = 4'hC;
  localparam int         WDP_LSB         = 0;
  localparam int         WDE_BIT         = 3;
  localparam int         WATCHDOG_CHANGE_ENABLE_BIT_BIT        = 4;
  localparam int         FLG_POR         = 0;
  localparam int         FLG_EXT         = 1;
  localparam int         FLG_BOD         = 2;
  localparam int         FLG_WDT         = 3;
  localparam int         FLG_JTR         = 4;
  localparam int         CMD_RESTART_BIT = 0;
  localparam int         ANA_COMPARATOR_BANDGAP_SELECT_BIT    = 0;
  localparam int         ANA_ADC_BIT     = 1;
  localparam int         CHG_WINDOW_CYC  = 4;
  localparam int         WDT_BASE_CYC    = 16384;
  localparam int         CLK_HZ          = 125_000_000;
  localparam int         WDT_OSC_HZ      = 1_000_000;
  localparam int         WDT_TICK_CYC    = CLK_HZ / WDT_OSC_HZ;
  localparam int         REL_DELAY_CYC   = 65536;
  localparam logic [2:0] WDP_RESET       = 3'h0;

  typedef struct packed {
    logic       chg;
    logic       en;
    logic [2:0] watchdog_prescaler_field;
  } rwc_wdt_cfg_t;

  typedef struct packed {
    logic jtr;
    logic wdt;
    logic supply_drop_detector;
    logic ext;
    logic por;
  } rwc_src_t;

  typedef enum logic [1:0] {RWC_RUN, RWC_HOLD, RWC_DELAY} rwc_state_t;
endpackage

// ---- rtl/rwc_reset_wdt.sv ----
// Reset controller with watchdog and Avalon-MM registers
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module rwc_reset_wdt #(
  parameter int REL_DELAY = rwc_pkg::REL_DELAY_CYC,
  parameter int WDT_BASE  = rwc_pkg::WDT_BASE_CYC,
  parameter int TICK_DIV  = rwc_pkg::WDT_TICK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        por_low,
  input  wire logic        pin_reset_n,
  input  wire logic        supply_drop_detector_en,
  input  wire logic        supply_drop_low,
  input  wire logic        test_port_reset,
  input  wire logic        watchdog_lock_fuse,
  input  wire logic        wdt_restart,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             port_reset_async,
  output logic             core_reset,
  output logic             bandgap_en,
  output logic [21:0]      wdt_count
);
  // Two-stage synchronisers for external levels
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  always_ff @(posedge ref_clk) begin
    sync1_r <= {por_low, ~pin_reset_n, supply_drop_low & supply_drop_detector_en,
                test_port_reset, wdt_restart};
    sync2_r <= sync1_r;
  end
  logic por_s, ext_s, bod_s, jtr_s, wdr_s;
  assign {por_s, ext_s, bod_s, jtr_s, wdr_s} = sync2_r;

  // Port pins go to reset without a clock from pin, power, supply-drop and test-port; core_reset adds the watchdog
  assign port_reset_async = por_low | ~pin_reset_n | test_port_reset |
    (supply_drop_low & supply_drop_detector_en) | core_reset;

  logic wdt_fire_r;
  rwc_pkg::rwc_src_t src;
  assign src = {jtr_s, wdt_fire_r, bod_s, ext_s, por_s};
  logic any_src;
  assign any_src = |src;

  // Release sequencer
  rwc_pkg::rwc_state_t st_r;
  logic [31:0] dly_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r  <= rwc_pkg::RWC_HOLD;
      dly_r <= 32'h0000_0000;
    end else begin
      case (st_r)
        rwc_pkg::RWC_RUN: begin
          if (any_src) st_r <= rwc_pkg::RWC_HOLD;
        end
        rwc_pkg::RWC_HOLD: begin
          dly_r <= 32'h0000_0000;
          if (!any_src) st_r <= rwc_pkg::RWC_DELAY;
        end
        rwc_pkg::RWC_DELAY: begin
          if (any_src) st_r <= rwc_pkg::RWC_HOLD;
          else if (dly_r >= 32'(REL_DELAY - 1)) st_r <= rwc_pkg::RWC_RUN;
          else dly_r <= dly_r + 32'h0000_0001;
        end
        default: st_r <= rwc_pkg::RWC_HOLD;
      endcase
    end
  end
  assign core_reset = (st_r != rwc_pkg::RWC_RUN) | any_src;

  // Watchdog configuration
  function automatic logic reg_hit(input logic [3:0] a,
                                   input logic [3:0] off);
    return a == off;
  endfunction

  rwc_pkg::rwc_wdt_cfg_t cfg_r;
  logic [2:0] win_r;
  logic wr_ctrl, sw_kick;
  logic [31:0] wd;
  assign wd      = avs_writedata;
  assign wr_ctrl = avs_write & reg_hit(avs_address, rwc_pkg::ADDR_WDT_CTRL);
  logic lvl2;
  assign lvl2 = watchdog_lock_fuse;
  logic wdt_on;
  assign wdt_on = lvl2 | cfg_r.en;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || core_reset) begin
      cfg_r.chg <= 1'b0;
      cfg_r.en  <= 1'b0;
      cfg_r.watchdog_prescaler_field <= rwc_pkg::WDP_RESET;
      win_r     <= 3'h0;
    end else if (wr_ctrl && wd[rwc_pkg::WATCHDOG_CHANGE_ENABLE_BIT_BIT] && wd[rwc_pkg::WDE_BIT]) begin
      cfg_r.chg <= 1'b1;
      cfg_r.en  <= 1'b1;
      win_r     <= 3'(rwc_pkg::CHG_WINDOW_CYC);
    end else if (wr_ctrl && cfg_r.chg && !wd[rwc_pkg::WATCHDOG_CHANGE_ENABLE_BIT_BIT]) begin
      cfg_r.chg <= 1'b0;
      win_r     <= 3'h0;
      cfg_r.watchdog_prescaler_field <= wd[rwc_pkg::WDP_LSB +: 3];
      if (!lvl2) cfg_r.en <= wd[rwc_pkg::WDE_BIT];
    end else begin
      if (wr_ctrl && wd[rwc_pkg::WDE_BIT]) cfg_r.en <= 1'b1;
      if (win_r != 3'h0) win_r <= win_r - 3'h1;
      if (win_r == 3'h1) cfg_r.chg <= 1'b0;
    end
  end

  // Watchdog 1 MHz tick and counter
  logic [7:0] tick_r;
  logic tick;
  assign tick = (tick_r == 8'(TICK_DIV - 1));
  always_ff @(posedge ref_clk) begin
    if (!rst_n || tick) tick_r <= 8'h00;
    else tick_r <= tick_r + 8'h01;
  end

  logic [21:0] wcnt_r;
  logic [21:0] limit;
  assign limit = 22'(WDT_BASE) << cfg_r.watchdog_prescaler_field;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || core_reset || !wdt_on || wdr_s || sw_kick) begin
      wcnt_r     <= 22'h00_0000;
      wdt_fire_r <= 1'b0;
    end else if (tick) begin
      if (wcnt_r >= limit - 22'h00_0001) begin
        wcnt_r     <= 22'h00_0000;
        wdt_fire_r <= 1'b1;
      end else begin
        wcnt_r     <= wcnt_r + 22'h00_0001;
        wdt_fire_r <= 1'b0;
      end
    end else begin
      wdt_fire_r <= 1'b0;
    end
  end
  assign wdt_count = wcnt_r;

  // Analog controls and bandgap
  logic [1:0] ana_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || core_reset) ana_r <= 2'h0;
    else if (avs_write && avs_address == rwc_pkg::ADDR_ANA_CTRL)
      ana_r <= wd[1:0];
  end
  assign bandgap_en = supply_drop_detector_en | ana_r[rwc_pkg::ANA_COMPARATOR_BANDGAP_SELECT_BIT] |
                      ana_r[rwc_pkg::ANA_ADC_BIT];

  // Reset cause flags; set wins over clear
  logic [4:0] flg_r;
  logic wr_flg;
  assign wr_flg = avs_write & reg_hit(avs_address, rwc_pkg::ADDR_RST_CAUSE);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) flg_r <= 5'h00;
    else if (src.por) flg_r <= 5'h01;
    else begin
      flg_r <= (wr_flg ? (flg_r & wd[4:0]) : flg_r) | src;
    end
  end

  // Software restart command
  logic sw_restart;
  assign sw_restart = avs_write & reg_hit(avs_address, rwc_pkg::ADDR_WDT_CMD) &
                      wd[rwc_pkg::CMD_RESTART_BIT];
  logic sw_rst_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) sw_rst_r <= 1'b0;
    else sw_rst_r <= sw_restart;
  end

  // Bus: writes zero-wait, reads one wait state
  logic rd_ack_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rd_ack_r <= 1'b0;
    else rd_ack_r <= avs_read & ~rd_ack_r;
  end
  assign avs_waitrequest = avs_read & ~rd_ack_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !rd_ack_r) begin
      case (avs_address)
        rwc_pkg::ADDR_WDT_CTRL:
          avs_readdata <= {27'h0, cfg_r.chg, wdt_on, cfg_r.watchdog_prescaler_field};
        rwc_pkg::ADDR_RST_CAUSE: avs_readdata <= {27'h0, flg_r};
        rwc_pkg::ADDR_ANA_CTRL:  avs_readdata <= {30'h0, ana_r};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
  assign sw_kick = sw_rst_r;

  chk_fire_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdt_fire_r |=> !wdt_fire_r) else $error("fire too long");
  chk_fire_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdt_fire_r |-> core_reset) else $error("no reset");
  chk_src_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    any_src |-> core_reset) else $error("source no reset");
  chk_delay_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(any_src) |-> core_reset[*2]) else $error("no delay");
  chk_win_close: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(cfg_r.chg) && !wr_ctrl ##1 !wr_ctrl[*3] |=> !cfg_r.chg)
    else $error("window open");
  chk_lvl2_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lvl2 |-> wdt_on) else $error("lvl2 off");
  chk_en_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_r.en && !cfg_r.chg && !core_reset |=> cfg_r.en)
    else $error("en lost");
  chk_bandgap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    supply_drop_detector_en |-> bandgap_en) else $error("bg off");
  chk_cnt_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wdt_on |=> wcnt_r == 22'h00_0000) else $error("cnt run");
  cov_wdt_fire: cover property (@(posedge ref_clk) wdt_fire_r);
  cov_release: cover property (@(posedge ref_clk) $fell(core_reset));
  cov_seq: cover property (@(posedge ref_clk) $fell(cfg_r.chg) && cfg_r.en);

  // Checks sharing one clock and reset
  default clocking rwc_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_wr_nowait: assert property (
    avs_write
    |-> !avs_waitrequest)
    else $error("write stalled");

  chk_rd_answer: assert property (
    avs_read
    |-> ##[0:1] !avs_waitrequest)
    else $error("read not answered");

  chk_pin_async: assert property (
    !pin_reset_n
    |-> port_reset_async)
    else $error("pin reset not on ports");

  chk_por_async: assert property (
    por_low
    |-> port_reset_async)
    else $error("power reset not on ports");

  chk_jtr_hold: assert property (
    jtr_s
    |-> core_reset)
    else $error("test-port reset lost");

  chk_bod_hold: assert property (
    bod_s
    |-> core_reset)
    else $error("supply drop reset lost");

  chk_ext_hold: assert property (
    ext_s
    |-> core_reset)
    else $error("pin reset lost");

  chk_por_flag: assert property (
    por_s
    |=> flg_r == 5'h01)
    else $error("power flag wrong");

  chk_wdt_flag: assert property (
    src.wdt && !src.por
    |=> flg_r[rwc_pkg::FLG_WDT])
    else $error("watchdog flag not set");

  chk_flag_clear: assert property (
    wr_flg && !(|src)
    |=> flg_r == ($past(flg_r) & $past(avs_writedata[4:0])))
    else $error("flag clear wrong");

  chk_hold_state: assert property (
    any_src
    |=> st_r == rwc_pkg::RWC_HOLD)
    else $error("source did not hold");

  chk_dly_stretch: assert property (
    st_r == rwc_pkg::RWC_DELAY && dly_r < 32'(REL_DELAY - 1)
    |=> core_reset)
    else $error("delay cut short");

  chk_dly_clear: assert property (
    st_r == rwc_pkg::RWC_HOLD
    |=> dly_r == 32'h0000_0000)
    else $error("delay not restarted");

  chk_run_clean: assert property (
    st_r == rwc_pkg::RWC_RUN && !any_src
    |-> !core_reset)
    else $error("reset stuck");

  chk_cfg_reset: assert property (
    core_reset
    |=> !cfg_r.en && !cfg_r.chg && ana_r == 2'h0)
    else $error("config kept in reset");

  chk_fire_delay: assert property (
    $fell(wdt_fire_r) && !any_src
    |=> st_r == rwc_pkg::RWC_DELAY)
    else $error("delay not started");

  chk_win_load: assert property (
    wr_ctrl && wd[rwc_pkg::WATCHDOG_CHANGE_ENABLE_BIT_BIT] && wd[rwc_pkg::WDE_BIT] && !core_reset
    |=> cfg_r.chg && win_r == 3'(rwc_pkg::CHG_WINDOW_CYC))
    else $error("window not opened");

  chk_chg_timeout: assert property (
    win_r == 3'h1 && !wr_ctrl && !core_reset
    |=> !cfg_r.chg)
    else $error("change enable stuck");

  chk_lvl2_wdp: assert property (
    lvl2 && wr_ctrl && cfg_r.chg && !wd[rwc_pkg::WATCHDOG_CHANGE_ENABLE_BIT_BIT] && !core_reset
    |=> cfg_r.watchdog_prescaler_field == $past(avs_writedata[2:0]))
    else $error("prescaler not taken");

  chk_wdp_locked: assert property (
    !cfg_r.chg && !(wr_ctrl && wd[rwc_pkg::WATCHDOG_CHANGE_ENABLE_BIT_BIT]) && !core_reset
    |=> $stable(cfg_r.watchdog_prescaler_field))
    else $error("prescaler changed");

  chk_l1_disable: assert property (
    !lvl2 && wr_ctrl && cfg_r.chg && !wd[rwc_pkg::WATCHDOG_CHANGE_ENABLE_BIT_BIT] &&
    !wd[rwc_pkg::WDE_BIT] && !core_reset |=> !cfg_r.en)
    else $error("watchdog not disabled");

  chk_l1_enable: assert property (
    !lvl2 && wr_ctrl && wd[rwc_pkg::WDE_BIT] && !core_reset
    |=> cfg_r.en)
    else $error("watchdog not enabled");

  chk_cnt_kick: assert property (
    sw_kick || wdr_s || core_reset
    |=> wcnt_r == 22'h00_0000)
    else $error("counter not cleared");

  chk_tick_wrap: assert property (
    tick
    |=> tick_r == 8'h00)
    else $error("tick divider wrong");

  chk_bandgap_off: assert property (
    !supply_drop_detector_en && ana_r == 2'h0
    |-> !bandgap_en)
    else $error("bandgap left on");

  chk_rd_ctrl: assert property (
    avs_read && !rd_ack_r && avs_address == rwc_pkg::ADDR_WDT_CTRL
    |=> avs_readdata[rwc_pkg::WDE_BIT] == $past(wdt_on))
    else $error("enable read wrong");

  cov_lvl2_seq: cover property (lvl2 && $fell(cfg_r.chg));
  cov_kick: cover property (sw_kick || wdr_s);
endmodule // rwc_reset_wdt

// ---- tb/rwc_partner.sv ----
// Far side model: supply monitors, reset pin and core restarts
`timescale 1ns/1ps
module rwc_partner (
  input  wire logic       ref_clk,
  input  wire logic [3:0] src_req,
  input  wire logic       kick_en,
  output logic            por_low,
  output logic            pin_reset_n,
  output logic            supply_drop_low,
  output logic            test_port_reset,
  output logic            wdt_restart
);
  logic [7:0] kick_cnt_r = 8'h00;
  initial {por_low, supply_drop_low, test_port_reset, wdt_restart} = 4'h0;
  initial pin_reset_n = 1'b1;
  always @(posedge ref_clk) begin
    por_low         <= src_req[0];
    pin_reset_n     <= ~src_req[1];
    supply_drop_low <= src_req[2];
    test_port_reset <= src_req[3];
    kick_cnt_r      <= kick_cnt_r + 8'h01;
    wdt_restart     <= kick_en && kick_cnt_r == 8'h00;
  end
endmodule // rwc_partner

// ---- tb/testbench.sv ----
// Self-checking bench for the reset and watchdog block
`timescale 1ns/1ps
module testbench;
  localparam int REL = 16;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        watchdog_lock_fuse = 1'b0;
  logic        supply_drop_detector_en = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        kick_en = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [3:0]  src_req = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest, port_reset_async, core_reset, bandgap_en;
  logic        por_low, pin_reset_n, supply_drop_low, test_port_reset;
  logic        wdt_restart;
  logic [21:0] wdt_count;
  logic [4:0]  flag_bit [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
  int          error_cnt = 0;
  int          tests_run = 0;
  int          n;
  always #4 ref_clk = ~ref_clk;
  rwc_reset_wdt #(.REL_DELAY(REL), .WDT_BASE(4), .TICK_DIV(125))
    rwc_reset_wdt_inst (.ref_clk, .rst_n, .por_low, .pin_reset_n,
    .supply_drop_detector_en, .supply_drop_low, .test_port_reset,
    .watchdog_lock_fuse, .wdt_restart, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .port_reset_async,
    .core_reset, .bandgap_en, .wdt_count);
  rwc_partner rwc_partner_inst (.ref_clk, .src_req, .kick_en, .por_low,
    .pin_reset_n, .supply_drop_low, .test_port_reset, .wdt_restart);
  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_write     <= w;
    avs_read      <= ~w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    if (!w) rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a, input int e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, 32'(e), rd);
  endtask
  task automatic wait_cr(input logic v, output int c);
    c = 0;
    while (core_reset !== v) begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_cr(1'b0, n);
    chk("rel_delay", 1, n >= REL && n <= REL + 6);
    rdchk("ctrl_init", 4'h0, 0);
    rdchk("unmapped", 4'h1, 0);
    for (int i = 0; i < 3; i++) begin
      supply_drop_detector_en <= i == 0;
      bus(1'b1, 4'hC, 32'(i));
      @(posedge ref_clk);
      chk("bandgap_on", 1, bandgap_en);
    end
    bus(1'b1, 4'hC, 32'h0000_0000);
    @(posedge ref_clk);
    chk("bandgap_off", 0, bandgap_en);
    supply_drop_detector_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'h4, 32'h0000_0000);
      src_req[i] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("port_reset", 1, port_reset_async);
      chk("core_reset", 1, core_reset);
      src_req[i] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      wait_cr(1'b0, n);
      chk("src_stretch", 1, n >= REL - 3);
      rdchk("cause", 4'h4, flag_bit[i]);
    end
    bus(1'b1, 4'h0, 32'h0000_0008);
    rdchk("wde_set", 4'h0, 8);
    bus(1'b1, 4'h0, 32'h0000_0001);
    rdchk("wde_kept", 4'h0, 8);
    bus(1'b1, 4'h0, 32'h0000_0018);
    repeat (6) @(posedge ref_clk);
    bus(1'b1, 4'h0, 32'h0000_0000);
    rdchk("chg_closed", 4'h0, 8);
    bus(1'b1, 4'h0, 32'h0000_0018);
    bus(1'b1, 4'h0, 32'h0000_0000);
    rdchk("wde_off", 4'h0, 0);
    repeat (700) @(posedge ref_clk);
    chk("count_idle", 0, wdt_count);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 4'h4, 32'h0000_0000);
      if (p == 1) bus(1'b1, 4'h0, 32'h0000_0018);
      bus(1'b1, 4'h0, 32'(8 + p));
      wait_cr(1'b1, n);
      chk("wdt_period", 1, n > 500 * (p + 1) - 135 && n < 500 * (p + 1) + 20);
      wait_cr(1'b0, n);
      chk("wdt_stretch", 1, n >= REL);
      rdchk("wdt_flag", 4'h4, 8);
    end
    kick_en <= 1'b1;
    bus(1'b1, 4'h0, 32'h0000_0008);
    repeat (1500) @(posedge ref_clk);
    chk("kicked", 0, core_reset);
    bus(1'b1, 4'h8, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("sw_kick", 0, wdt_count);
    watchdog_lock_fuse <= 1'b1;
    rst_n              <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_cr(1'b0, n);
    rdchk("lvl2_init", 4'h0, 8);
    bus(1'b1, 4'h0, 32'h0000_0000);
    rdchk("lvl2_keep", 4'h0, 8);
    bus(1'b1, 4'h0, 32'h0000_0018);
    bus(1'b1, 4'h0, 32'h0000_0002);
    rdchk("lvl2_wdp", 4'h0, 10);
    final_report;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    final_report;
  end
endmodule // testbench
